// ### rtl/mqs_pkg.sv
// Purpose: shared constants and carrier types for the strap and flag bus control block
// Assumes: one system clock at 40 MHz
// Notes: register map is a small wishbone word map
`default_nettype none
package mqs_pkg;
    // selects
    localparam int unsigned SEL_W = 8;
    localparam int unsigned DEV_W = 3;
    localparam int unsigned QUE_W = 5;
    localparam int unsigned SECTOR_W = 8;
    localparam int unsigned NUM_QUEUES = 16;
    localparam int unsigned OV_DELAY = 2;
    // register byte offsets
    localparam logic [7:0] REG_STRAPS = 8'h00;
    localparam logic [7:0] REG_PAF = 8'h04;
    localparam logic [7:0] REG_EMPTY = 8'h08;
    localparam logic [7:0] REG_SCAN = 8'h0C;
    // reset values
    localparam logic [15:0] PAF_RST = 16'hFFFF;
    localparam logic [15:0] EMPTY_RST = 16'hFFFF;
    localparam logic [2:0] DEV_RST = 3'h0;
    localparam int unsigned MRS_SYNC_STAGES = 2;

    // straps captured at full reset
    typedef struct packed {
        logic flag_polled;
        logic primary;
        logic out_narrow;
        logic in_narrow;
        logic [2:0] dev_num;
    } mqs_straps_t;

    // almost-full scan output group
    typedef struct packed {
        logic [7:0] bus;
        logic sync;
        logic token;
        logic bus_oe_n;
    } mqs_scan_t;

    typedef enum logic [1:0] {
        SCAN_IDLE = 2'b00,
        SCAN_SEC1 = 2'b01,
        SCAN_SEC2 = 2'b11
    } mqs_scan_state_t;
endpackage : mqs_pkg
`default_nettype wire

// ### rtl/mqs_sync2.sv
// Purpose: two flip-flop synchroniser for a pin input
// Assumes: input asynchronous to sys_clk_i
// Notes: first stage read only by second stage
`default_nettype none
module mqs_sync2 #(
    parameter int unsigned W = 1
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    // two stage capture
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= d_i;
            sync_q <= meta_q;
        end
    end

    assign q_o = sync_q;
endmodule : mqs_sync2
`default_nettype wire

// ### rtl/mqs_delay.sv
// Purpose: fixed depth pipeline for a small word
// Assumes: same clock domain
// Notes: reset value is a parameter
`default_nettype none
module mqs_delay #(
    parameter int unsigned W = 1,
    parameter int unsigned DEPTH = 2,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] pipe_q [DEPTH];

    // shift stages
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < DEPTH; i++) begin
                pipe_q[i] <= RST_VAL;
            end
        end else begin
            pipe_q[0] <= d_i;
            for (int i = 1; i < DEPTH; i++) begin
                pipe_q[i] <= pipe_q[i-1];
            end
        end
    end

    assign q_o = pipe_q[DEPTH-1];
endmodule : mqs_delay
`default_nettype wire

// ### rtl/mqs_ctrl.sv
// Purpose: strap capture, device select, output ownership and almost-full scan
// Assumes: write and read ports share sys_clk_i; straps and full reset come from pins
// Notes: two-way pins are split into value and active-low enable
// Function
// - polled mode alternates sector one, sector two
// - sync high with sector one, low sector two
// - token pulses with sector two; token loads sector one
// - select is 3 device, 5 queue bits
// - respond only when device bits match
// - device number captured at full reset
// - input width strap: low x18, high x9
// - output width strap: low x18, high x9
// - primary role strap high means primary
// - secondary keeps shared outputs off after reset
// - full reset is high, low, high
// - primary: drive enable low drives data
// - secondary drives data only once selected
// - valid flag follows selection two cycles later
// - valid flag high when queue empty
// - valid flag output can float
// - flag mode strap high polled, low direct
// - direct mode: strobe loads addressed sector
// - status bus eight bits, two sectors
//
// The implementer's own choices: the register offsets and the Wishbone interface to the registers.
`default_nettype none
module mqs_ctrl
    import mqs_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // device pins
    input wire logic full_reset_n_i,
    input wire logic [2:0] device_number_straps_i,
    input wire logic input_width_strap_i,
    input wire logic output_width_strap_i,
    input wire logic primary_role_strap_i,
    input wire logic flag_scan_mode_strap_i,
    input wire logic [7:0] write_queue_select_i,
    input wire logic write_select_en_i,
    input wire logic [7:0] read_queue_select_i,
    input wire logic read_select_en_i,
    input wire logic almost_full_sector_strobe_i,
    input wire logic almost_full_token_in_i,
    input wire logic read_drive_en_n_i,
    output logic [7:0] almost_full_status_bus_o,
    output logic almost_full_status_bus_oe_n_o,
    output logic almost_full_scan_sync_o,
    output logic almost_full_scan_sync_oe_n_o,
    output logic almost_full_token_out_o,
    output logic read_data_oe_n_o,
    output logic read_data_valid_n_o,
    output logic read_data_valid_oe_n_o,
    output logic write_selected_o,
    output logic read_selected_o,
    output logic in_narrow_o,
    output logic out_narrow_o
);
    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    localparam int unsigned PIN_W = 32;
    logic [PIN_W-1:0] pin_raw;
    logic [PIN_W-1:0] pin_s;

    assign pin_raw = {full_reset_n_i, device_number_straps_i, input_width_strap_i,
                      output_width_strap_i, primary_role_strap_i, flag_scan_mode_strap_i,
                      write_queue_select_i, write_select_en_i, read_queue_select_i,
                      read_select_en_i, almost_full_sector_strobe_i,
                      almost_full_token_in_i, read_drive_en_n_i, 3'h0}; // 29 pins, 3 pad

    mqs_sync2 #(.W(PIN_W)) u_sync (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .d_i(pin_raw),
        .q_o(pin_s)
    );

    logic mrs_n_s;
    logic [2:0] dev_s;
    logic iw_s, ow_s, prim_s, fm_s;
    logic [7:0] wsel_s, rsel_s;
    logic wsel_en_s, rsel_en_s, almost_full_sector_strobe_s, tok_in_s, oe_n_s;

    assign {mrs_n_s, dev_s, iw_s, ow_s, prim_s, fm_s, wsel_s, wsel_en_s, rsel_s,
            rsel_en_s, almost_full_sector_strobe_s, tok_in_s, oe_n_s} = pin_s[PIN_W-1:3];

    ////////////////////////////////////////////////////////////////////////
    // full reset sequence: high, low, high again
    logic mrs_prev_q;
    logic in_mrs;
    logic mrs_seen_high_q;

    assign in_mrs = mrs_seen_high_q && !mrs_n_s;

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            mrs_prev_q <= 1'b0;
            mrs_seen_high_q <= 1'b0;
        end else begin
            mrs_prev_q <= mrs_n_s;
            if (mrs_n_s) begin
                mrs_seen_high_q <= 1'b1;
            end
        end
    end

    logic mrs_release;
    assign mrs_release = mrs_n_s && !mrs_prev_q && mrs_seen_high_q;

    ////////////////////////////////////////////////////////////////////////
    // strap capture while full reset is held low
    mqs_straps_t straps_q;
    logic configured_q;

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            straps_q <= '0;
            configured_q <= 1'b0;
        end else if (in_mrs) begin
            straps_q.dev_num <= dev_s;
            straps_q.in_narrow <= iw_s;
            straps_q.out_narrow <= ow_s;
            straps_q.primary <= prim_s;
            straps_q.flag_polled <= fm_s;
            configured_q <= 1'b0;
        end else if (mrs_release) begin
            configured_q <= 1'b1;
        end
    end

    assign in_narrow_o = straps_q.in_narrow;
    assign out_narrow_o = straps_q.out_narrow;

    ////////////////////////////////////////////////////////////////////////
    // device select compare on upper select bits
    logic wr_match, rd_match;
    logic wr_sel_q, rd_sel_q;
    logic [QUE_W-1:0] wr_queue_q, rd_queue_q;

    assign wr_match = wsel_s[SEL_W-1 -: DEV_W] == straps_q.dev_num;
    assign rd_match = rsel_s[SEL_W-1 -: DEV_W] == straps_q.dev_num;

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i || in_mrs) begin
            wr_sel_q <= 1'b0;
            rd_sel_q <= 1'b0;
            wr_queue_q <= '0;
            rd_queue_q <= '0;
        end else if (configured_q) begin
            if (wsel_en_s) begin
                wr_sel_q <= wr_match;
                wr_queue_q <= wsel_s[QUE_W-1:0];
            end
            if (rsel_en_s) begin
                rd_sel_q <= rd_match;
                rd_queue_q <= rsel_s[QUE_W-1:0];
            end
        end
    end

    assign write_selected_o = wr_sel_q;
    assign read_selected_o = rd_sel_q;

    ////////////////////////////////////////////////////////////////////////
    // status registers written by software: per-queue almost-full and empty
    logic [15:0] paf_q;
    logic [15:0] empty_q;
    logic wb_hit;

    assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            paf_q <= PAF_RST;
            empty_q <= EMPTY_RST;
        end else if (wb_hit && wb_we_i) begin
            if (wb_adr_i == REG_PAF) begin
                if (wb_sel_i[0]) paf_q[7:0] <= wb_dat_i[7:0];
                if (wb_sel_i[1]) paf_q[15:8] <= wb_dat_i[15:8];
            end
            if (wb_adr_i == REG_EMPTY) begin
                if (wb_sel_i[0]) empty_q[7:0] <= wb_dat_i[7:0];
                if (wb_sel_i[1]) empty_q[15:8] <= wb_dat_i[15:8];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read data drive enable, asynchronous pin path
    logic may_drive;
    assign may_drive = configured_q && (straps_q.primary || rd_sel_q);
    assign read_data_oe_n_o = !(may_drive && !read_drive_en_n_i);

    ////////////////////////////////////////////////////////////////////////
    // read data valid flag, two-stage delay
    logic rd_empty_now;
    logic ov_raw;
    logic ov_oe_raw;
    logic [1:0] ov_pair;

    assign rd_empty_now = (rd_queue_q < QUE_W'(NUM_QUEUES)) ?
                          empty_q[rd_queue_q[3:0]] : 1'b1;
    assign ov_raw = !rd_sel_q || rd_empty_now;
    assign ov_oe_raw = !(configured_q && (straps_q.primary || rd_sel_q));

    mqs_delay #(.W(2), .DEPTH(OV_DELAY), .RST_VAL(2'b11)) u_ov_dly (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .d_i({ov_raw, ov_oe_raw}),
        .q_o(ov_pair)
    );

    assign read_data_valid_n_o = ov_pair[1];
    assign read_data_valid_oe_n_o = ov_pair[0];

    ////////////////////////////////////////////////////////////////////////
    // almost-full scan: polled ring or direct strobe
    mqs_scan_state_t scan_q;
    mqs_scan_t scan_out_q;
    logic tok_prev_q;
    logic tok_rise;

    assign tok_rise = tok_in_s && !tok_prev_q;

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            tok_prev_q <= 1'b0;
        end else begin
            tok_prev_q <= tok_in_s;
        end
    end

    // primary starts the ring once after reset
    logic kick_q;
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i || in_mrs) begin
            kick_q <= 1'b0;
        end else if (mrs_release) begin
            kick_q <= 1'b1;
        end else begin
            kick_q <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i || in_mrs || !configured_q) begin
            scan_q <= SCAN_IDLE;
            scan_out_q <= '{bus: 8'h00, sync: 1'b0, token: 1'b0, bus_oe_n: 1'b1};
        end else if (straps_q.flag_polled) begin
            scan_out_q.token <= 1'b0;
            unique case (scan_q)
                SCAN_IDLE: begin
                    if (tok_rise || (kick_q && straps_q.primary)) begin
                        scan_q <= SCAN_SEC1;
                        scan_out_q.bus <= paf_q[7:0];
                        scan_out_q.sync <= 1'b1;
                        scan_out_q.bus_oe_n <= 1'b0;
                    end else begin
                        scan_out_q.bus_oe_n <= 1'b1;
                        scan_out_q.sync <= 1'b0;
                    end
                end
                SCAN_SEC1: begin
                    scan_q <= SCAN_SEC2;
                    scan_out_q.bus <= paf_q[15:8];
                    scan_out_q.sync <= 1'b0;
                    scan_out_q.token <= 1'b1;
                end
                SCAN_SEC2: begin
                    if (tok_rise) begin
                        scan_q <= SCAN_SEC1;
                        scan_out_q.bus <= paf_q[7:0];
                        scan_out_q.sync <= 1'b1;
                    end else begin
                        scan_q <= SCAN_IDLE;
                        scan_out_q.bus_oe_n <= 1'b1;
                    end
                end
                default: begin
                    scan_q <= SCAN_IDLE;
                end
            endcase
        end else begin
            scan_q <= SCAN_IDLE;
            scan_out_q.token <= 1'b0;
            scan_out_q.sync <= 1'b0;
            if (almost_full_sector_strobe_s) begin
                scan_out_q.bus_oe_n <= !wr_match;
                scan_out_q.bus <= wsel_s[0] ? paf_q[15:8] : paf_q[7:0];
            end
        end
    end

    assign almost_full_status_bus_o = scan_out_q.bus;
    assign almost_full_status_bus_oe_n_o = scan_out_q.bus_oe_n;
    assign almost_full_scan_sync_o = scan_out_q.sync;
    assign almost_full_scan_sync_oe_n_o = scan_out_q.bus_oe_n || !straps_q.flag_polled;
    assign almost_full_token_out_o = scan_out_q.token;

    ////////////////////////////////////////////////////////////////////////
    // wishbone read mux and ack
    logic [31:0] rd_word;
    always_comb begin
        rd_word = 32'h0000_0000;
        unique case (wb_adr_i)
            REG_STRAPS: rd_word = {23'h0, configured_q, 1'b0, straps_q};
            REG_PAF: rd_word = {16'h0, paf_q};
            REG_EMPTY: rd_word = {16'h0, empty_q};
            REG_SCAN: rd_word = {24'h0, rd_sel_q, wr_sel_q, scan_q,
                                 scan_out_q.sync, scan_out_q.token,
                                 scan_out_q.bus_oe_n, read_data_valid_n_o};
            default: rd_word = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wb_hit;
            wb_dat_o <= (wb_hit && !wb_we_i) ? rd_word : 32'h0000_0000;
        end
    end
endmodule : mqs_ctrl
`default_nettype wire

// ### sim/mqs_ctrl_assertions.sv
// Purpose: port checks for the strap and flag bus control block
// Assumes: one clock, sync active-low reset
// Notes: bound to every mqs_ctrl instance
`default_nettype none
module mqs_ctrl_assertions (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic [31:0] wb_dat_o,
    input wire logic read_drive_en_n_i,
    input wire logic read_data_oe_n_o,
    input wire logic almost_full_status_bus_oe_n_o,
    input wire logic almost_full_scan_sync_o,
    input wire logic almost_full_scan_sync_oe_n_o,
    input wire logic almost_full_token_out_o
);
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rst_n_i);
    ////////////////////////////////////////
    // bus answer timing
    a_ack_follows_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack not one cycle after request");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data not zero outside ack");
    ////////////////////////////////////////
    // data drive and scan sequence
    a_float_when_off: assert property (read_drive_en_n_i |-> read_data_oe_n_o)
        else $error("data driven while drive enable high");
    a_sync_alternates: assert property (almost_full_scan_sync_o |=> !almost_full_scan_sync_o)
        else $error("sector one not followed by sector two");
    a_sync_drives_bus: assert property (almost_full_scan_sync_o |->
        !almost_full_status_bus_oe_n_o && !almost_full_scan_sync_oe_n_o)
        else $error("sync high while bus floating");
    a_token_after_sec1: assert property (almost_full_scan_sync_o |=>
        almost_full_token_out_o && !almost_full_status_bus_oe_n_o)
        else $error("token missing with sector two");
    a_token_one_pulse: assert property (almost_full_token_out_o |=> !almost_full_token_out_o)
        else $error("token pulse longer than one cycle");
    a_token_needs_sec1: assert property (almost_full_token_out_o |->
        $past(almost_full_scan_sync_o) && !almost_full_scan_sync_o)
        else $error("token without preceding sector one");
    c_scan: cover property (almost_full_scan_sync_o);
    c_token: cover property (almost_full_token_out_o);
    c_drive: cover property (!read_data_oe_n_o);
endmodule : mqs_ctrl_assertions

bind mqs_ctrl mqs_ctrl_assertions mqs_ctrl_assertions_inst (.sys_clk_i, .rst_n_i, .wb_cyc_i,
    .wb_stb_i, .wb_ack_o, .wb_dat_o, .read_drive_en_n_i, .read_data_oe_n_o,
    .almost_full_status_bus_oe_n_o, .almost_full_scan_sync_o, .almost_full_scan_sync_oe_n_o,
    .almost_full_token_out_o);
`default_nettype wire

// ### sim/mqs_ring_peer.sv
// Purpose: chained peer that passes the scan token back
// Assumes: same clock as the device
// Notes: loop mode models a lone device wired to itself
`default_nettype none
module mqs_ring_peer
    import mqs_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic loop_i,
    input wire logic [3:0] lag_i,
    input wire logic token_i,
    output logic token_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [4:0] cnt_q;
    logic busy_q;
    logic pulse_q;
    // lone device: token output fed straight back
    assign token_o = loop_i ? token_i : pulse_q;
    // peer shows its two sectors after a lag, then passes the token on
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            busy_q <= 1'b0;
            cnt_q <= 5'h00;
            pulse_q <= 1'b0;
        end else begin
            pulse_q <= 1'b0;
            if (token_i && !loop_i) begin
                busy_q <= 1'b1;
                cnt_q <= {1'b0, lag_i} + 5'h02;
            end else if (busy_q && cnt_q == 5'h00) begin
                busy_q <= 1'b0;
                pulse_q <= 1'b1;
            end else if (busy_q) begin
                cnt_q <= cnt_q - 5'h01;
            end
        end
    end
endmodule : mqs_ring_peer
`default_nettype wire

// ### sim/mqs_ctrl_tb.sv
// Purpose: self-checking bench for the strap and flag bus control block
// Assumes: 40 MHz clock, wishbone answered by the design
// Notes: expected values come from model variables and a sector queue
`default_nettype none
module mqs_ctrl_tb
    import mqs_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
    logic [7:0] adr = 8'h00, wq = 8'h00, rq = 8'h00, bus;
    logic [3:0] sel = 4'h0, lag = 4'h0;
    logic [31:0] wdat = 32'h0, rdat, rd;
    logic frst_n = 1'b1, iw = 1'b0, ow = 1'b0, pri = 1'b1, pol = 1'b1, wen = 1'b0;
    logic ren = 1'b0, stro = 1'b0, den_n = 1'b1, loop = 1'b1, tin, tout;
    logic [2:0] dev = 3'h0;
    logic bus_oe_n, sync, sync_oe_n, doe_n, vld_n, vld_oe_n, wsel_o, rsel_o, inn, outn;
    logic [15:0] paf_m, empty_m;
    logic [7:0] exp_q[$];
    int failures = 0, checks = 0, cyc_cnt = 0;
    always #12.5 clk = ~clk;
    mqs_ctrl mqs_ctrl_inst (.sys_clk_i(clk), .rst_n_i(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .full_reset_n_i(frst_n), .device_number_straps_i(dev),
        .input_width_strap_i(iw), .output_width_strap_i(ow), .primary_role_strap_i(pri),
        .flag_scan_mode_strap_i(pol), .write_queue_select_i(wq), .write_select_en_i(wen),
        .read_queue_select_i(rq), .read_select_en_i(ren), .almost_full_sector_strobe_i(stro),
        .almost_full_token_in_i(tin), .read_drive_en_n_i(den_n), .almost_full_status_bus_o(bus),
        .almost_full_status_bus_oe_n_o(bus_oe_n), .almost_full_scan_sync_o(sync),
        .almost_full_scan_sync_oe_n_o(sync_oe_n), .almost_full_token_out_o(tout),
        .read_data_oe_n_o(doe_n), .read_data_valid_n_o(vld_n), .read_data_valid_oe_n_o(vld_oe_n),
        .write_selected_o(wsel_o), .read_selected_o(rsel_o), .in_narrow_o(inn),
        .out_narrow_o(outn));
    mqs_ring_peer mqs_ring_peer_inst (.sys_clk_i(clk), .rst_n_i(rst_n), .loop_i(loop),
        .lag_i(lag), .token_i(tout), .token_o(tin));
    ////////////////////////////////////////
    // shared tasks
    task automatic end_sim();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            failures++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick
    task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        adr <= a;
        we <= w;
        wdat <= d;
        sel <= 4'hF;
        do @(posedge clk); while (ack !== 1'b1);
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb
    task automatic cfg_chk();
        tick(1);
        frst_n <= 1'b0;
        tick(6);
        frst_n <= 1'b1;
        tick(8);
        wb(REG_STRAPS, 1'b0, 32'h0);
        chk("straps", {23'h0, 1'b1, 1'b0, pol, pri, ow, iw, dev}, rd);
        chk("widths", {30'h0, iw, ow}, {30'h0, inn, outn});
        wb(REG_PAF, 1'b1, {16'h0, paf_m});
        $display("test configuration done");
    endtask : cfg_chk
    task automatic scan_chk();
        int n;
        n = 0;
        exp_q.push_back(paf_m[7:0]);
        exp_q.push_back(paf_m[15:8]);
        while (tout !== 1'b1 && n < 80) begin
            tick(1);
            n++;
        end
        tick(1);
        while (sync !== 1'b1 && n < 80) begin
            tick(1);
            n++;
        end
        chk("sector one", {24'h0, exp_q.pop_front()}, {24'h0, bus});
        tick(1);
        chk("sector two", {24'h0, exp_q.pop_front()}, {24'h0, bus});
        chk("sync and token", 32'h1, {30'h0, sync, tout});
        $display("test scan done");
    endtask : scan_chk
    // hang guard
    always @(posedge clk) begin
        cyc_cnt++;
        if (cyc_cnt == 20000) begin
            failures++;
            end_sim();
        end
    end
    ////////////////////////////////////////
    // main sequence
    initial begin
        int q;
        int n;
        q = $urandom(34);
        dev <= 3'($urandom_range(7, 0));
        iw <= 1'($urandom_range(1, 0));
        ow <= 1'($urandom_range(1, 0));
        paf_m = 16'($urandom_range(65535, 0));
        q = $urandom_range(15, 0);
        tick(20);
        rst_n <= 1'b1;
        wb(REG_PAF, 1'b0, 32'h0);
        chk("paf reset", {16'h0, PAF_RST}, rd);
        wb(REG_EMPTY, 1'b0, 32'h0);
        chk("empty reset", {16'h0, EMPTY_RST}, rd);
        wb(8'h10, 1'b1, 32'h5A5A);
        wb(8'h10, 1'b0, 32'h0);
        chk("unmapped", 32'h0, rd);
        $display("test registers done");
        cfg_chk();
        scan_chk();
        loop <= 1'b0;
        lag <= 4'h5;
        scan_chk();
        for (int i = 0; i < 8; i++) begin
            wq <= {i[2:0], 5'h03};
            rq <= {i[2:0], 5'h04};
            wen <= 1'b1;
            ren <= 1'b1;
            tick(6);
            chk("selected", {30'h0, {2{i[2:0] == dev}}}, {30'h0, wsel_o, rsel_o});
        end
        for (int v = 0; v < 2; v++) begin
            den_n <= v[0];
            tick(2);
            chk("drive enable", {31'h0, v[0]}, {31'h0, doe_n});
        end
        empty_m = 16'hFFFF ^ (16'h1 << q);
        wb(REG_EMPTY, 1'b1, {16'h0, empty_m});
        rq <= {dev, 5'h1F};
        tick(8);
        chk("valid empty", 32'h1, {31'h0, vld_n});
        rq <= {dev, 5'(q)};
        tick(2);
        chk("valid early", 32'h1, {31'h0, vld_n});
        tick(6);
        chk("valid late", 32'h0, {30'h0, vld_oe_n, vld_n});
        $display("test select done");
        pol <= 1'b0;
        pri <= 1'b0;
        den_n <= 1'b0;
        wen <= 1'b0;
        ren <= 1'b0;
        cfg_chk();
        chk("secondary float", 32'h3, {30'h0, doe_n, bus_oe_n});
        wq <= {dev, 5'h01};
        wen <= 1'b1;
        stro <= 1'b1;
        tick(1);
        stro <= 1'b0;
        n = 0;
        while (bus_oe_n !== 1'b0 && n < 20) begin
            tick(1);
            n++;
        end
        chk("direct sector", {24'h0, paf_m[15:8]}, {24'h0, bus});
        wq <= {~dev, 5'h00};
        stro <= 1'b1;
        tick(1);
        stro <= 1'b0;
        rq <= {dev, 5'(q)};
        ren <= 1'b1;
        tick(8);
        chk("direct other", 32'h1, {30'h0, doe_n, bus_oe_n});
        $display("test direct done");
        end_sim();
    end
endmodule : mqs_ctrl_tb
`default_nettype wire
